// file: wwd_cnt_if.sv
// Carrier between watchdog control and its prescaler/postscaler chain
`timescale 1ns/10ps
`default_nettype none
interface wwd_cnt_if;
   logic             tick;
   logic             clr;
   logic             pre_sel;
   logic [3:0]       post_sel;
   logic             timeout;
   logic             in_window;

   modport ctrl (output tick, clr, pre_sel, post_sel, input timeout, in_window);
   modport scl  (input tick, clr, pre_sel, post_sel, output timeout, in_window);
endinterface : wwd_cnt_if
`default_nettype wire

// file: wwd_pkg.sv
// Constants and types shared by the windowed watchdog files
package wwd_pkg;

   localparam int          CLK_HZ       = 20_000_000;
   localparam int          RC_HZ        = 32_000;
   localparam int          RC_DIV       = CLK_HZ / RC_HZ;
   localparam int          DIV_W        = 10;

   localparam logic [3:0]  CFG_OFS      = 4'h0;
   localparam logic [3:0]  RCTL_OFS     = 4'h4;

   localparam logic [7:0]  CFG_RESET    = 8'hFF;
   localparam int          CFG_FE_BIT   = 7;
   localparam int          CFG_WD_BIT   = 6;
   localparam int          CFG_RSV_BIT  = 5;
   localparam int          CFG_PRE_BIT  = 4;
   localparam int          CFG_POST_LSB = 0;
   localparam int          POST_W       = 4;

   localparam int          RC_SWEN_BIT  = 5;
   localparam int          RC_TO_BIT    = 4;
   localparam int          RC_SLEEP_BIT = 3;
   localparam int          RC_IDLE_BIT  = 2;

   localparam int          PRE_W        = 7;
   localparam logic [6:0]  PRE_MAX_LONG = 7'h7F;
   localparam logic [6:0]  PRE_MAX_SHRT = 7'h1F;
   localparam int          PRE_LOG_LONG = 7;
   localparam int          PRE_LOG_SHRT = 5;
   localparam int          PST_W        = 15;
   localparam int          ELAP_W       = 23;

   typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_IDLE} wwd_mode_t;

endpackage : wwd_pkg

// file: wwd_scaler.sv
// Prescaler and postscaler chain counting low-power RC ticks to a time-out
`timescale 1ns/10ps
`default_nettype none
module wwd_scaler
   import wwd_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   wwd_cnt_if.scl    cif
);
   logic [PRE_W-1:0]  pre_cnt_q;
   logic [PST_W-1:0]  post_cnt_q;
   logic [6:0]        pre_max;
   logic [15:0]       post_one;
   logic [15:0]       post_lim;
   logic              wrap_pre;
   logic              wrap_all;
   logic [4:0]        shamt;
   logic [ELAP_W-1:0] elapsed;
   logic [ELAP_W-1:0] total;
   logic [ELAP_W-1:0] thresh;

   assign pre_max  = cif.pre_sel ? PRE_MAX_LONG : PRE_MAX_SHRT;
   assign post_one = 16'h0001 << cif.post_sel;
   assign post_lim = 16'(post_one - 16'h0001);
   assign wrap_pre = (pre_cnt_q == pre_max);
   assign wrap_all = wrap_pre && (post_cnt_q == post_lim[PST_W-1:0]);

   // Counters zeroed on any clear cause; clear beats a pending tick
   always_ff @(posedge clock)
   begin
      if (rst || cif.clr)
      begin
         pre_cnt_q  <= '0;
         post_cnt_q <= '0;
      end
      else if (cif.tick)
      begin
         pre_cnt_q  <= wrap_pre ? '0 : PRE_W'(pre_cnt_q + 7'h01);
         if (wrap_pre)
            post_cnt_q <= wrap_all ? '0 : PST_W'(post_cnt_q + 15'h0001);
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst || cif.clr)
         cif.timeout <= 1'b0;
      else
         cif.timeout <= cif.tick && wrap_all;
   end

   // Final quarter of the period, measured in raw ticks
   assign shamt   = 5'(cif.post_sel) + (cif.pre_sel ? 5'(PRE_LOG_LONG) : 5'(PRE_LOG_SHRT));
   assign elapsed = (ELAP_W'(post_cnt_q) << (cif.pre_sel ? PRE_LOG_LONG : PRE_LOG_SHRT))
                    | ELAP_W'(pre_cnt_q);
   assign total   = ELAP_W'(1) << shamt;
   assign thresh  = total - (total >> 2);
   assign cif.in_window = (elapsed >= thresh);

   clr_zero_a: assert property (@(posedge clock) disable iff (rst)
      cif.clr |=> (pre_cnt_q == '0) && (post_cnt_q == '0))
      else $error("scaler counts not zero after clear");

   count_on_a: assert property (@(posedge clock) disable iff (rst)
      cif.tick && !cif.clr && !wrap_pre |=> pre_cnt_q == PRE_W'($past(pre_cnt_q) + 7'h01))
      else $error("prescaler did not advance on tick");

endmodule : wwd_scaler
`default_nettype wire

// file: wwd_top.sv
// Windowed watchdog: control, power-save tracking and Avalon-MM registers
`timescale 1ns/10ps
`default_nettype none
module wwd_top
   import wwd_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        clear_instr,
   input  wire logic        power_save_instr,
   input  wire logic        power_save_idle,
   input  wire logic        clock_switch_done,
   input  wire logic        sys_reset_evt,
   input  wire logic        wake_event,
   output logic             wdt_reset_req,
   output logic             wake_req,
   output logic             rc_clock_on,
   output logic             power_save_active
);

   wwd_cnt_if cif ();

   logic [7:0]       cfg_q;
   logic             soft_en_q;
   logic             to_flag_q;
   logic             sleep_flag_q;
   logic             idle_flag_q;
   logic             wait_q;
   logic [DIV_W-1:0] div_q;
   logic             tick_q;
   wwd_mode_t        mode_q;
   wwd_mode_t        mode_d;

   logic             running;
   logic             window_mode;
   logic             bus_wr;
   logic             wr_cfg;
   logic             wr_rctl;
   logic             early_clear;
   logic             run_timeout;
   logic             ps_timeout;
   logic             ps_exit;
   logic             ps_enter;
   logic [7:0]       rctl_val;

   // Register bus: one wait state on every access
   always_ff @(posedge clock)
   begin
      if (rst)
         wait_q <= 1'b1;
      else if (wait_q && (avs_read || avs_write))
         wait_q <= 1'b0;
      else
         wait_q <= 1'b1;
   end

   assign avs_waitrequest = wait_q;
   assign bus_wr  = avs_write && !wait_q && avs_byteenable[0];
   assign wr_cfg  = bus_wr && (avs_address == CFG_OFS);
   assign wr_rctl = bus_wr && (avs_address == RCTL_OFS);

   always_comb
   begin
      rctl_val               = 8'h00;
      rctl_val[RC_SWEN_BIT]  = soft_en_q;
      rctl_val[RC_TO_BIT]    = to_flag_q;
      rctl_val[RC_SLEEP_BIT] = sleep_flag_q;
      rctl_val[RC_IDLE_BIT]  = idle_flag_q;
   end

   // Unmapped offsets read as zero and ignore writes
   always_ff @(posedge clock)
   begin
      if (rst)
         avs_readdata <= 32'h0000_0000;
      else if (wait_q && avs_read)
      begin
         if (avs_address == CFG_OFS)
            avs_readdata <= {24'h00_0000, cfg_q};
         else if (avs_address == RCTL_OFS)
            avs_readdata <= {24'h00_0000, rctl_val};
         else
            avs_readdata <= 32'h0000_0000;
      end
   end

   // Configuration word; the reserved bit always reads as one
   always_ff @(posedge clock)
   begin
      if (rst)
         cfg_q <= CFG_RESET;
      else if (wr_cfg)
      begin
         cfg_q              <= avs_writedata[7:0];
         cfg_q[CFG_RSV_BIT] <= 1'b1;
      end
   end

   assign window_mode = !cfg_q[CFG_WD_BIT];
   assign running     = cfg_q[CFG_FE_BIT] || soft_en_q;

   // Software enable
   always_ff @(posedge clock)
   begin
      if (rst || sys_reset_evt)
         soft_en_q <= 1'b0;
      else if (wr_rctl)
         soft_en_q <= avs_writedata[RC_SWEN_BIT];
   end

   // RC source model: a tick every RC_DIV clocks; a clear restarts its phase so periods start on a whole tick
   always_ff @(posedge clock)
   begin
      if (rst || !running || cif.clr)
      begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end
      else if (div_q == DIV_W'(RC_DIV - 1))
      begin
         div_q  <= '0;
         tick_q <= 1'b1;
      end
      else
      begin
         div_q  <= DIV_W'(div_q + 10'h001);
         tick_q <= 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         rc_clock_on <= 1'b0;
      else
         rc_clock_on <= running;
   end

   // Event decode
   assign early_clear = clear_instr && (mode_q == PS_RUN) && running
                        && window_mode && !cif.in_window;
   assign run_timeout = cif.timeout && (mode_q == PS_RUN);
   assign ps_timeout  = cif.timeout && (mode_q != PS_RUN);
   assign ps_exit     = (mode_q != PS_RUN) && (ps_timeout || wake_event);
   assign ps_enter    = power_save_instr && (mode_q == PS_RUN);

   // Power-save mode tracking
   always_comb
   begin
      mode_d = mode_q;
      case (mode_q)
         PS_RUN:
         begin
            if (power_save_instr)
               mode_d = power_save_idle ? PS_IDLE : PS_SLEEP;
         end
         PS_SLEEP, PS_IDLE:
         begin
            if (ps_exit)
               mode_d = PS_RUN;
         end
         default:
            mode_d = PS_RUN;
      endcase
      if (sys_reset_evt)
         mode_d = PS_RUN;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         mode_q <= PS_RUN;
      else
         mode_q <= mode_d;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         power_save_active <= 1'b0;
      else
         power_save_active <= (mode_d != PS_RUN);
   end

   // Reset and wake requests are single-cycle pulses
   always_ff @(posedge clock)
   begin
      if (rst || sys_reset_evt)
      begin
         wdt_reset_req <= 1'b0;
         wake_req      <= 1'b0;
      end
      else
      begin
         wdt_reset_req <= run_timeout || early_clear;
         wake_req      <= ps_timeout;
      end
   end

   // Status flags: a hardware set wins over a software write in the same cycle
   always_ff @(posedge clock)
   begin
      if (rst)
         to_flag_q <= 1'b0;
      else if (cif.timeout || early_clear)
         to_flag_q <= 1'b1;
      else if (wr_rctl)
         to_flag_q <= avs_writedata[RC_TO_BIT];
   end

   // Flags survive the wake so software can tell which mode it left
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sleep_flag_q <= 1'b0;
         idle_flag_q  <= 1'b0;
      end
      else
      begin
         if (ps_enter && !power_save_idle)
            sleep_flag_q <= 1'b1;
         else if (wr_rctl)
            sleep_flag_q <= avs_writedata[RC_SLEEP_BIT];
         if (ps_enter && power_save_idle)
            idle_flag_q <= 1'b1;
         else if (wr_rctl)
            idle_flag_q <= avs_writedata[RC_IDLE_BIT];
      end
   end

   // Counter chain hookup; stopping the watchdog also restarts its period
   assign cif.tick     = tick_q;
   assign cif.pre_sel  = cfg_q[CFG_PRE_BIT];
   assign cif.post_sel = cfg_q[CFG_POST_LSB +: POST_W];
   assign cif.clr      = sys_reset_evt || clock_switch_done || power_save_instr
                         || ps_exit || clear_instr || !running;

   wwd_scaler u_scaler (
      .clock (clock),
      .rst   (rst),
      .cif   (cif)
   );

   sequence bus_req_s;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   sequence bus_ack_s;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   bus_answer_a: assert property (@(posedge clock) disable iff (rst)
      bus_req_s |=> bus_ack_s)
      else $error("register access not answered after one wait state");

   swen_reset_a: assert property (@(posedge clock) disable iff (rst)
      sys_reset_evt |=> !soft_en_q)
      else $error("software enable survived device reset");

   force_run_a: assert property (@(posedge clock) disable iff (rst)
      !rst && cfg_q[CFG_FE_BIT] && !wr_cfg |=> rc_clock_on && running)
      else $error("forced watchdog not running");

   soft_off_a: assert property (@(posedge clock) disable iff (rst)
      !running ##1 !running |-> !rc_clock_on && !tick_q)
      else $error("watchdog ran while disabled");

   tick_space_a: assert property (@(posedge clock) disable iff (rst)
      tick_q |=> !tick_q [*8])
      else $error("RC ticks too close together");

   flag_hold_a: assert property (@(posedge clock) disable iff (rst)
      to_flag_q && !wr_rctl |=> to_flag_q)
      else $error("time-out flag dropped without a write");

   run_reset_a: assert property (@(posedge clock) disable iff (rst)
      run_timeout && !sys_reset_evt |=> wdt_reset_req && to_flag_q && !wake_req)
      else $error("run-mode time-out did not reset");

   ps_wake_a: assert property (@(posedge clock) disable iff (rst)
      ps_timeout && !sys_reset_evt |=> wake_req && !wdt_reset_req && (mode_q == PS_RUN))
      else $error("power-save time-out did not wake");

   window_early_a: assert property (@(posedge clock) disable iff (rst)
      early_clear && !sys_reset_evt |=> wdt_reset_req ##1 !wdt_reset_req)
      else $error("early clear in window mode did not reset");

   normal_clear_a: assert property (@(posedge clock) disable iff (rst)
      clear_instr && cfg_q[CFG_WD_BIT] && !cif.timeout |=> !wdt_reset_req)
      else $error("clear in normal mode caused a reset");

   flag_set_a: assert property (@(posedge clock) disable iff (rst)
      cif.timeout || early_clear |=> to_flag_q)
      else $error("time-out flag not set by a time-out");

   rc_follow_a: assert property (@(posedge clock) disable iff (rst)
      !rst |=> rc_clock_on == $past(running))
      else $error("RC clock enable does not follow the run state");

   div_restart_a: assert property (@(posedge clock) disable iff (rst)
      cif.clr |=> !tick_q && (div_q == '0))
      else $error("RC divider not restarted by a clear cause");

   sequence sleep_entry_s;
      ps_enter && !power_save_idle && !sys_reset_evt;
   endsequence

   sleep_flag_a: assert property (@(posedge clock) disable iff (rst)
      sleep_entry_s |=> sleep_flag_q && power_save_active && (mode_q == PS_SLEEP))
      else $error("sleep entry not recorded");

   sequence idle_entry_s;
      ps_enter && power_save_idle && !sys_reset_evt;
   endsequence

   idle_flag_a: assert property (@(posedge clock) disable iff (rst)
      idle_entry_s |=> idle_flag_q && power_save_active && (mode_q == PS_IDLE))
      else $error("idle entry not recorded");

endmodule : wwd_top
`default_nettype wire

// file: wwd_top_test.sv
// Self-checking bench for the windowed watchdog top level
`timescale 1ns/10ps
`default_nettype none
module wwd_top_test
   import wwd_pkg::*;
;

   typedef struct {
      logic [3:0]  a;
      logic [7:0]  d;
      logic [3:0]  be;
      logic [31:0] e;
   } wwd_row_t;

   logic        clock;
   logic        rst;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        clear_instr;
   logic        power_save_instr;
   logic        power_save_idle;
   logic        clock_switch_done;
   logic        sys_reset_evt;
   logic        wake_event;
   logic        wdt_reset_req;
   logic        wake_req;
   logic        rc_clock_on;
   logic        power_save_active;
   int          error_cnt;
   int          n_tests;
   int          n;
   logic [31:0] rd;

   // Each row is written, then read back from the same place
   wwd_row_t    rows [6] = '{
      '{CFG_OFS,  8'h00, 4'h1, 32'h20},
      '{RCTL_OFS, 8'hFF, 4'h1, 32'h3C},
      '{RCTL_OFS, 8'h00, 4'h0, 32'h3C},
      '{4'h8,     8'hFF, 4'h1, 32'h00},
      '{RCTL_OFS, 8'h00, 4'h1, 32'h00},
      '{CFG_OFS,  8'hDF, 4'h1, 32'hFF}};

   wwd_top i_dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .clear_instr(clear_instr),
      .power_save_instr(power_save_instr), .power_save_idle(power_save_idle),
      .clock_switch_done(clock_switch_done), .sys_reset_evt(sys_reset_evt), .wake_event(wake_event),
      .wdt_reset_req(wdt_reset_req), .wake_req(wake_req), .rc_clock_on(rc_clock_on),
      .power_save_active(power_save_active));

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic tally_and_finish;
      $display("errors %0d compares %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   task automatic hang(input string what);
      error_cnt++;
      $display("wrong value at %0t: %s never came", $time, what);
      tally_and_finish();
   endtask : hang

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_reg

   task automatic chk_bit(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chk_bit

   task automatic tick(input int k);
      repeat (k) @(posedge clock);
   endtask : tick

   // Holds the request until the edge that sees waitrequest low
   task automatic wait_ack;
      int i;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clock);
         if (avs_waitrequest === 1'b0)
            break;
      end
      if (i == 20)
         hang("bus answer");
   endtask : wait_ack

   task automatic bus_write(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= be;
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
      @(posedge clock);
   endtask : bus_write

   task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask : bus_read

   // One-cycle event pulse: 0 clear, 1 power save, 2 clock switch, 3 device reset, 4 wake
   task automatic fire(input int k);
      case (k)
         0: clear_instr <= 1'b1;
         1: power_save_instr <= 1'b1;
         2: clock_switch_done <= 1'b1;
         3: sys_reset_evt <= 1'b1;
         default: wake_event <= 1'b1;
      endcase
      @(posedge clock);
      {clear_instr, power_save_instr, clock_switch_done, sys_reset_evt, wake_event} <= 5'h00;
   endtask : fire

   task automatic wait_ev(input logic sel, input int lim, output int cnt);
      for (cnt = 0; cnt < lim; cnt++)
      begin
         @(posedge clock);
         if ((sel ? wake_req : wdt_reset_req) === 1'b1)
            break;
      end
   endtask : wait_ev

   // Restart the count without a window check, then clear after gap cycles
   task automatic win_case(input logic [7:0] cfg, input int gap, input logic exp_rst);
      bus_write(CFG_OFS, cfg, 4'h1);
      fire(2);
      tick(gap);
      fire(0);
      wait_ev(1'b0, 4, n);
      chk_bit(n < 4, exp_rst, "window reset");
   endtask : win_case

   initial
   begin
      rst = 1'b1;
      error_cnt = 0;
      n_tests = 0;
      {avs_address, avs_byteenable} = 8'h00;
      {avs_read, avs_write} = 2'h0;
      avs_writedata = 32'h00000000;
      {clear_instr, power_save_instr, power_save_idle} = 3'h0;
      {clock_switch_done, sys_reset_evt, wake_event} = 3'h0;
      tick(5);
      rst <= 1'b0;
      tick(2);
      chk_bit(rc_clock_on, 1'b1, "rc clock after reset");
      bus_read(CFG_OFS, rd);
      chk_reg(rd, 32'hFF, "config reset");
      bus_read(RCTL_OFS, rd);
      chk_reg(rd, 32'h00, "control reset");
      foreach (rows[i])
      begin
         bus_write(rows[i].a, rows[i].d, rows[i].be);
         bus_read(rows[i].a, rd);
         chk_reg(rd, rows[i].e, "register row");
      end
      bus_write(CFG_OFS, 8'h40, 4'h1);
      tick(3);
      chk_bit(rc_clock_on, 1'b0, "rc clock soft off");
      bus_write(RCTL_OFS, 8'h20, 4'h1);
      tick(3);
      chk_bit(rc_clock_on, 1'b1, "rc clock soft on");
      bus_write(RCTL_OFS, 8'h00, 4'h1);
      bus_write(CFG_OFS, 8'hC0, 4'h1);
      tick(3);
      chk_bit(rc_clock_on, 1'b1, "rc clock forced");
      // Shortest period is 32 ticks of 625 clocks; a clear a quarter of the way in must restart it
      fire(2);
      tick(5000);
      fire(0);
      wait_ev(1'b0, 21000, n);
      if (n == 21000)
         hang("run time-out");
      chk_bit(n > 19990 && n < 20010, 1'b1, "run period");
      bus_read(RCTL_OFS, rd);
      chk_reg(rd, 32'h10, "flag after run time-out");
      bus_write(RCTL_OFS, 8'h30, 4'h1);
      fire(3);
      tick(2);
      bus_read(RCTL_OFS, rd);
      chk_reg(rd, 32'h10, "after device reset");
      bus_write(RCTL_OFS, 8'h00, 4'h1);
      fire(1);
      tick(2);
      chk_bit(power_save_active, 1'b1, "sleep entered");
      wait_ev(1'b1, 21000, n);
      if (n == 21000)
         hang("sleep wake");
      chk_bit(n > 19990 && n < 20010, 1'b1, "sleep period");
      tick(2);
      chk_bit(power_save_active, 1'b0, "woken");
      bus_read(RCTL_OFS, rd);
      chk_reg(rd, 32'h18, "flags after wake");
      bus_write(RCTL_OFS, 8'h00, 4'h1);
      power_save_idle <= 1'b1;
      fire(1);
      power_save_idle <= 1'b0;
      tick(2);
      chk_bit(power_save_active, 1'b1, "idle entered");
      fire(4);
      tick(2);
      chk_bit(power_save_active, 1'b0, "idle left");
      bus_read(RCTL_OFS, rd);
      chk_reg(rd, 32'h04, "idle flag");
      bus_write(RCTL_OFS, 8'h00, 4'h1);
      win_case(8'h80, 16000, 1'b0);
      win_case(8'h80, 1000, 1'b1);
      win_case(8'h90, 16000, 1'b1);
      win_case(8'h81, 16000, 1'b1);
      tally_and_finish();
   end

   initial
   begin
      tick(100000);
      hang("end of run");
   end

endmodule : wwd_top_test
`default_nettype wire
